// ==== verilog/fltc_pkg.sv ====
// shared constants and types of the flash/torch mode controller
package fltc_pkg;
    // ****************************************
    // register addresses and field positions
    // ****************************************
    localparam logic [2:0] ADDR_MASTER = 3'h0;
    localparam logic [2:0] ADDR_FLASH  = 3'h1;
    localparam logic [2:0] ADDR_TORCH  = 3'h2;
    localparam int         ADDR_LSBS   = 3;
    localparam int         ON_BIT      = 3;
    localparam int         SHORT_BIT   = 2;
    localparam int         OPEN_BIT    = 1;
    localparam int         FGO_BIT     = 4;
    localparam int         TGO_BIT     = 4;
    localparam int         INH_BIT     = 5;
    localparam int         TMR_LSB     = 5;
    localparam int         TMR_MSB     = 7;
    localparam int         LVL_MSB     = 3;
    localparam logic [7:0] FLASH_RST   = 8'hE0;
    localparam logic [7:0] TORCH_RST   = 8'h00;
    localparam logic [7:0] TORCH_MASK  = 8'h3F;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ      = 100;
    localparam int BLANK_MS     = 1000;
    localparam int RETRY_MS     = 100;
    localparam int TMO_STEP_US  = 156250;
    localparam int BLANK_CYC    = BLANK_MS * 1000 * CLK_MHZ;
    localparam int RETRY_CYC    = RETRY_MS * 1000 * CLK_MHZ;
    localparam int TMO_STEP_CYC = TMO_STEP_US * CLK_MHZ;
    localparam int TW           = 27;

    // operating modes
    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_STANDBY,
        MODE_FLASH,
        MODE_TORCH,
        MODE_RETRY,
        MODE_OVERVOLT
    } fltc_mode_t;
endpackage

// ==== verilog/fltc_timer.sv ====
// interval timer that flags expiry after a run of limit cycles
`timescale 1ns/10ps
module fltc_timer #(
    parameter int W = 27
) (
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    input  wire logic         run,
    input  wire logic [W-1:0] limit,
    output logic              expired
);
    import fltc_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         exp;
    } fltc_tmr_t;

    fltc_tmr_t q;
    fltc_tmr_t d;

    // count while running, restart whenever run drops
    always_comb begin
        d = q;
        if (!run) begin
            d.cnt = '0;
            d.exp = 1'b0;
        end else if (!q.exp) begin
            if (q.cnt >= limit - W'(1)) begin
                d.exp = 1'b1;
            end else begin
                d.cnt = q.cnt + W'(1);
            end
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign expired = q.exp;
endmodule

// ==== verilog/fltc_ctrl.sv ====
// mode controller of a flash/torch led driver with register port
`timescale 1ns/10ps
module fltc_ctrl #(
    parameter logic [fltc_pkg::TW-1:0] BLANK_CYCLES    = fltc_pkg::TW'(fltc_pkg::BLANK_CYC),
    parameter logic [fltc_pkg::TW-1:0] RETRY_CYCLES    = fltc_pkg::TW'(fltc_pkg::RETRY_CYC),
    parameter logic [fltc_pkg::TW-1:0] TMO_STEP_CYCLES = fltc_pkg::TW'(fltc_pkg::TMO_STEP_CYC)
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    input  wire logic       chip_enable_pin,
    input  wire logic       flash_enable_pin,
    input  wire logic       torch_enable_pin,
    input  wire logic       flash_inhibit,
    input  wire logic       overvoltage_guard,
    input  wire logic [1:0] open_led_detector,
    input  wire logic [1:0] short_led_detector,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            standby_active,
    output logic            boost_en,
    output logic            sink_en,
    output logic      [1:0] ch_en,
    output logic            level_flash,
    output logic      [3:0] level_code
);
    import fltc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        fltc_mode_t mode;
        logic       enabled;
        logic       master_on;
        logic [7:0] flash_ctl;
        logic [7:0] torch_ctl;
        logic       fpin_prev;
        logic       tpin_prev;
        logic       fhold;
        logic       thold;
        logic       both_open_flag;
        logic       shorted_output_flag;
        logic [1:0] ch_off;
        logic [7:0] rdata;
        logic       boost;
        logic       sink;
        logic       lvl_flash;
        logic [3:0] lvl_code;
        logic [1:0] ch_en;
    } fltc_state_t;

    localparam fltc_state_t ST_RST = '{
        mode      : MODE_OFF,
        flash_ctl : FLASH_RST,
        torch_ctl : TORCH_RST,
        default   : '0
    };

    fltc_state_t    st_q;
    fltc_state_t    st_d;
    logic           en_req;
    logic           fl_req;
    logic           tr_req;
    logic           inhibit;
    logic           open_both;
    logic           short_any;
    logic           blank_exp;
    logic           tmo_exp;
    logic           retry_exp;
    logic [TW-1:0]  tmo_limit;
    logic [ADDR_LSBS-1:0] addr;

    // low-to-high transition between two samples
    function automatic logic rise(input logic prev, input logic cur);
        return !prev && cur;
    endfunction

    // ****************************************
    // timers
    // ****************************************
    // timeout is (code + 1) steps
    assign tmo_limit = (TW'(st_q.flash_ctl[TMR_MSB:TMR_LSB]) + TW'(1)) * TMO_STEP_CYCLES;

    // enable-low blanking, runs only while no enable request
    fltc_timer #(.W(TW)) u_blank (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ce       (ce),
        .run      (st_q.enabled && !en_req),
        .limit    (BLANK_CYCLES),
        .expired  (blank_exp)
    );

    // flash safety timer, restarted on each flash entry
    fltc_timer #(.W(TW)) u_tmo (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ce       (ce),
        .run      (st_q.mode == MODE_FLASH),
        .limit    (tmo_limit),
        .expired  (tmo_exp)
    );

    // fault retry wait
    fltc_timer #(.W(TW)) u_retry (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ce       (ce),
        .run      (st_q.mode == MODE_RETRY),
        .limit    (RETRY_CYCLES),
        .expired  (retry_exp)
    );

    // ****************************************
    // request decode
    // ****************************************
    // requests, inhibit and gated detectors
    assign addr      = reg_addr[ADDR_LSBS-1:0];
    assign en_req    = chip_enable_pin || st_q.master_on;
    assign fl_req    = st_q.fhold || st_q.flash_ctl[FGO_BIT];
    assign tr_req    = st_q.thold || st_q.torch_ctl[TGO_BIT];
    assign inhibit   = flash_inhibit || st_q.torch_ctl[INH_BIT];
    assign open_both = st_q.sink && (&open_led_detector);
    assign short_any = st_q.sink && (|short_led_detector);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_d           = st_q;
        st_d.fpin_prev = flash_enable_pin;
        st_d.tpin_prev = torch_enable_pin;

        // pin requests: set on rising edge, held while pin stays high
        if (rise(st_q.fpin_prev, flash_enable_pin)) begin
            st_d.fhold = 1'b1;
        end else if (!flash_enable_pin) begin
            st_d.fhold = 1'b0;
        end
        if (rise(st_q.tpin_prev, torch_enable_pin)) begin
            st_d.thold = 1'b1;
        end else if (!torch_enable_pin) begin
            st_d.thold = 1'b0;
        end

        // enable: immediate on request, off after blanking
        if (en_req) begin
            st_d.enabled = 1'b1;
        end else if (blank_exp) begin
            st_d.enabled = 1'b0;
        end

        // mode sequencing, flash wins over torch
        unique case (st_q.mode)
            MODE_OFF: begin
                if (st_q.enabled) begin
                    st_d.mode = MODE_STANDBY;
                end
            end
            MODE_STANDBY: begin
                if (fl_req) begin
                    st_d.mode = MODE_FLASH;
                end else if (tr_req) begin
                    st_d.mode = MODE_TORCH;
                end
            end
            MODE_FLASH: begin
                if (tmo_exp) begin
                    st_d.mode               = MODE_STANDBY;
                    st_d.fhold              = 1'b0;
                    st_d.flash_ctl[FGO_BIT] = 1'b0;
                end else if (!fl_req) begin
                    st_d.mode = tr_req ? MODE_TORCH : MODE_STANDBY;
                end
            end
            MODE_TORCH: begin
                if (fl_req) begin
                    st_d.mode = MODE_FLASH;
                end else if (!tr_req) begin
                    st_d.mode = MODE_STANDBY;
                end
            end
            MODE_RETRY: begin
                if (retry_exp) begin
                    st_d.mode = MODE_STANDBY;
                end
            end
            MODE_OVERVOLT: begin
                if (!overvoltage_guard) begin
                    st_d.mode = MODE_STANDBY;
                end
            end
            default: st_d.mode = MODE_OFF;
        endcase

        // fault shutdown overrides, strongest last
        if (open_both || short_any) begin
            st_d.mode = MODE_RETRY;
        end
        if (overvoltage_guard && st_q.mode != MODE_OFF) begin
            st_d.mode = MODE_OVERVOLT;
        end
        if (!st_d.enabled) begin
            st_d.mode = MODE_OFF;
        end

        // register writes after the sequencer so software wins
        if (reg_wr) begin
            unique case (addr)
                ADDR_MASTER: begin
                    st_d.master_on           = reg_wdata[ON_BIT];
                    st_d.both_open_flag      = 1'b0;
                    st_d.shorted_output_flag = 1'b0;
                end
                ADDR_FLASH: st_d.flash_ctl = reg_wdata;
                ADDR_TORCH: st_d.torch_ctl = reg_wdata & TORCH_MASK;
                default: ;
            endcase
        end

        // status flags, a detection beats a clearing write
        if (open_both) begin
            st_d.both_open_flag = 1'b1;
        end
        if (short_any) begin
            st_d.shorted_output_flag = 1'b1;
        end

        // single open channel is switched off, the other keeps going
        for (int i = 0; i < 2; i++) begin
            if (st_q.sink && open_led_detector[i] && !open_both) begin
                st_d.ch_off[i] = 1'b1;
            end
        end
        if (st_d.mode != MODE_FLASH && st_d.mode != MODE_TORCH) begin
            st_d.ch_off = 2'b00;
        end

        // register read data
        if (reg_rd) begin
            unique case (addr)
                ADDR_MASTER: st_d.rdata = {4'h0, st_q.master_on, st_q.shorted_output_flag,
                                           st_q.both_open_flag, 1'b0};
                ADDR_FLASH:  st_d.rdata = st_q.flash_ctl;
                ADDR_TORCH:  st_d.rdata = st_q.torch_ctl;
                default:     st_d.rdata = 8'h00;
            endcase
        end

        // regulator controls and level select
        st_d.sink      = st_d.mode == MODE_FLASH || st_d.mode == MODE_TORCH;
        st_d.boost     = st_d.sink;
        st_d.lvl_flash = st_d.mode == MODE_FLASH && !inhibit;
        st_d.lvl_code  = st_d.lvl_flash ? st_d.flash_ctl[LVL_MSB:0]
                                        : st_d.torch_ctl[LVL_MSB:0];
        st_d.ch_en     = st_d.sink ? ~st_d.ch_off : 2'b00;
    end

    // state register, frozen while ce is low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_RST;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata      = st_q.rdata;
    assign standby_active = st_q.enabled;
    assign boost_en       = st_q.boost;
    assign sink_en        = st_q.sink;
    assign ch_en          = st_q.ch_en;
    assign level_flash    = st_q.lvl_flash;
    assign level_code     = st_q.lvl_code;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence flash_rise_s;
        ce && !st_q.fpin_prev && flash_enable_pin && st_q.mode == MODE_STANDBY && !overvoltage_guard && !blank_exp;
    endsequence

    sequence flash_keep_s;
        ce && flash_enable_pin && !overvoltage_guard && !blank_exp;
    endsequence

    standby_entry_a: assert property (ce && chip_enable_pin |=> st_q.enabled)
        else $error("enable pin did not enable");
    blank_hold_a: assert property (st_q.enabled && ce && !blank_exp |=> st_q.enabled)
        else $error("shutdown before blanking elapsed");
    reg_enable_a: assert property (ce && reg_wr && addr == ADDR_MASTER && reg_wdata[ON_BIT] ##1 ce
                                   |=> st_q.enabled)
        else $error("master on bit did not enable");
    flash_start_a: assert property (flash_rise_s ##1 flash_keep_s |=> st_q.mode == MODE_FLASH)
        else $error("flash pin edge did not start flash");
    flash_end_a: assert property (ce && st_q.mode == MODE_FLASH && !fl_req |=> st_q.mode != MODE_FLASH)
        else $error("flash kept without request");
    flash_hold_a: assert property (ce && st_q.mode == MODE_FLASH && st_q.fhold && !tmo_exp && !blank_exp
                                   && !overvoltage_guard && !(&open_led_detector) && !(|short_led_detector)
                                   |=> st_q.mode == MODE_FLASH)
        else $error("flash dropped while requested");
    timeout_off_a: assert property (ce && !reg_wr && st_q.mode == MODE_FLASH && tmo_exp
                                    |=> st_q.mode != MODE_FLASH && !st_q.flash_ctl[FGO_BIT])
        else $error("flash survived safety timeout");
    overvolt_off_a: assert property (ce && overvoltage_guard |=> !boost_en && !sink_en)
        else $error("regulators on during overvoltage");
    detect_gate_a: assert property ($rose(st_q.mode == MODE_RETRY) |-> $past(st_q.sink))
        else $error("fault taken while regulator off");
    retry_wait_a: assert property (ce && st_q.mode == MODE_RETRY && retry_exp && !overvoltage_guard
                                   && !blank_exp |=> st_q.mode == MODE_STANDBY)
        else $error("no retry after fault wait");
    open_flag_a: assert property (ce && st_q.sink && (&open_led_detector) |=> st_q.both_open_flag)
        else $error("open flag not set");
    inhibit_level_a: assert property ($past(ce) && st_q.mode == MODE_FLASH
                                      |-> level_flash != $past(inhibit))
        else $error("inhibit level wrong in flash");
    flash_prio_a: assert property (ce && st_q.mode == MODE_TORCH && fl_req && !blank_exp && !overvoltage_guard
                                   && !(&open_led_detector) && !(|short_led_detector)
                                   |=> st_q.mode == MODE_FLASH)
        else $error("torch not preempted by flash");
endmodule

// ==== tb/fltc_host.sv ====
// host processor model: control pins and register strobe port
`timescale 1ns/10ps
module fltc_host (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    output logic            chip_enable_pin,
    output logic            flash_enable_pin,
    output logic            torch_enable_pin,
    output logic            flash_inhibit,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    // ****************************************
    // pin and register cycles
    // ****************************************
    // everything idle at time zero
    initial begin
        {chip_enable_pin, flash_enable_pin, torch_enable_pin, flash_inhibit} = 4'h0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    end

    // pin levels {enable, flash, torch, inhibit}, changed at falling edge
    task automatic pins(input logic [3:0] v);
        @(negedge core_clk);
        {chip_enable_pin, flash_enable_pin, torch_enable_pin, flash_inhibit} = v;
    endtask

    // one-cycle write strobe to any register address, then the bus is inverted
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;    // released bus keeps moving
        reg_wdata = ~d;
    endtask

    // one-cycle read strobe, data taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the flash/torch mode controller
`timescale 1ns/10ps
module testbench;
    import fltc_pkg::*;
    localparam int RETRY = 20;
    localparam int STEP  = 10;
    logic       core_clk = 1'b0;
    logic       resetn;
    logic       ce;
    logic       over_v;
    logic [1:0] opn;
    logic [1:0] sht;
    logic       en;
    logic       fpin;
    logic       tpin;
    logic       inh;
    logic       wr;
    logic       rd;
    logic       standby_active;
    logic       boost_en;
    logic       sink_en;
    logic       level_flash;
    logic [7:0] addr, wdata, rdata, d, fr, tr;
    logic [1:0] ch_en;
    logic [3:0] level_code;
    int         error_cnt   = 0;
    int         check_count = 0;

    // ****************************************
    // clock, design and host
    // ****************************************
    always #5 core_clk = ~core_clk;

    fltc_ctrl #(
        .BLANK_CYCLES       (27'h32),
        .RETRY_CYCLES       (27'h14),
        .TMO_STEP_CYCLES    (27'h0A)
    ) uut (
        .core_clk           (core_clk),
        .resetn             (resetn),
        .ce                 (ce),
        .chip_enable_pin    (en),
        .flash_enable_pin   (fpin),
        .torch_enable_pin   (tpin),
        .flash_inhibit      (inh),
        .overvoltage_guard  (over_v),
        .open_led_detector  (opn),
        .short_led_detector (sht),
        .reg_wr             (wr),
        .reg_rd             (rd),
        .reg_addr           (addr),
        .reg_wdata          (wdata),
        .reg_rdata          (rdata),
        .standby_active     (standby_active),
        .boost_en           (boost_en),
        .sink_en            (sink_en),
        .ch_en              (ch_en),
        .level_flash        (level_flash),
        .level_code         (level_code)
    );

    fltc_host host (
        .core_clk           (core_clk),
        .reg_rdata          (rdata),
        .chip_enable_pin    (en),
        .flash_enable_pin   (fpin),
        .torch_enable_pin   (tpin),
        .flash_inhibit      (inh),
        .reg_wr             (wr),
        .reg_rd             (rd),
        .reg_addr           (addr),
        .reg_wdata          (wdata)
    );

    // ****************************************
    // helpers
    // ****************************************
    // one comparison, mismatch reported at once
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // outputs while a mode drives the leds
    task automatic on_chk(input logic [1:0] ch, input logic lf, input logic [3:0] code);
        chk({level_code, standby_active, boost_en, sink_en, ch_en, level_flash}, {code, 3'h7, ch, lf});
    endtask

    // outputs with the leds dark
    task automatic off_chk(input logic sb);
        chk({standby_active, boost_en, sink_en, ch_en}, {sb, 4'h0});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // flash timeout length in cycles for a timer code
    function automatic int tmo(input logic [2:0] code);
        return (int'(code) + 1) * STEP;
    endfunction

    // level code in flash with or without inhibit
    function automatic logic [3:0] lvl(input logic [7:0] f, input logic [7:0] t, input logic inh);
        return inh ? t[3:0] : f[3:0];
    endfunction

    task automatic conclude;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        ce     = 1'b1;
        over_v = 1'b0;
        opn    = 2'h0;
        sht    = 2'h0;
        void'($urandom(32'h24C0));
        cyc(10);
        resetn = 1'b1;
        // reset values, address decode, masks
        host.rd(8'h01, d); chk(d, 8'hE0);
        host.rd(8'h09, d); chk(d, 8'hE0);
        host.rd(8'h00, d); chk(d, 8'h00);
        host.wr(8'h05, 8'hAA);
        host.rd(8'h05, d); chk(d, 8'h00);
        host.wr(8'h02, 8'hEF);
        host.rd(8'h02, d); chk(d, 8'h2F);
        host.wr(8'h02, 8'h00);
        off_chk(1'b0);
        // enable pin, blanking, master bit
        host.pins(4'h8); cyc(3); off_chk(1'b1);
        host.pins(4'h0); cyc(40);
        host.pins(4'h8); cyc(2); off_chk(1'b1);
        host.pins(4'h0); cyc(60); off_chk(1'b0);
        host.wr(8'h00, 8'h08); cyc(3); off_chk(1'b1);
        host.pins(4'h8);
        host.wr(8'h00, 8'h00);
        // flash by pin with random levels and inhibit
        for (int i = 0; i < 4; i++) begin
            fr = {4'hE, 4'($urandom)};
            tr = {4'h0, 4'($urandom)};
            host.wr(8'h01, fr);
            host.wr(8'h02, tr);
            host.pins(4'hC); cyc(3); on_chk(2'h3, 1'b1, lvl(fr, tr, 1'b0));
            host.pins(4'hD); cyc(3); on_chk(2'h3, 1'b0, lvl(fr, tr, 1'b1));
            host.pins(4'hC); cyc(3); on_chk(2'h3, 1'b1, lvl(fr, tr, 1'b0));
            host.pins(4'h8); cyc(3); off_chk(1'b1);
        end
        // flash by register, inhibit bit, safety timeout
        host.wr(8'h02, 8'h25);
        host.wr(8'h01, 8'h53);
        cyc(3); on_chk(2'h3, 1'b0, 4'h5);
        cyc(tmo(3'h2) - 6); on_chk(2'h3, 1'b0, 4'h5);
        cyc(8); off_chk(1'b1);
        host.rd(8'h01, d); chk(d, 8'h43);
        // either request keeps flash on, both must drop to end it
        host.wr(8'h02, 8'h00);
        host.wr(8'h01, 8'hF6);
        host.pins(4'hC);
        host.pins(4'h8); cyc(3); on_chk(2'h3, 1'b1, 4'h6);
        host.wr(8'h01, 8'hE6); cyc(3); off_chk(1'b1);
        // torch by pin and register, flash priority
        host.wr(8'h02, 8'h07);
        host.pins(4'hA); cyc(3); on_chk(2'h3, 1'b0, 4'h7);
        host.wr(8'h02, 8'h17);
        host.pins(4'h8); cyc(3); on_chk(2'h3, 1'b0, 4'h7);
        host.wr(8'h01, 8'hF9); cyc(3); on_chk(2'h3, 1'b1, 4'h9);
        host.wr(8'h01, 8'hE9); cyc(4); on_chk(2'h3, 1'b0, 4'h7);
        // detectors while regulating
        opn = 2'h1; cyc(3); on_chk(2'h2, 1'b0, 4'h7);
        opn = 2'h0;
        sht = 2'h2; cyc(3); off_chk(1'b1);
        sht = 2'h0; cyc(RETRY + 5); on_chk(2'h3, 1'b0, 4'h7);
        host.rd(8'h00, d); chk(d, 8'h04);
        host.wr(8'h00, 8'h00);
        opn = 2'h3; cyc(3); off_chk(1'b1);
        opn = 2'h0; cyc(RETRY + 5); on_chk(2'h3, 1'b0, 4'h7);
        host.rd(8'h00, d); chk(d, 8'h02);
        // overvoltage
        over_v = 1'b1; cyc(3); chk({boost_en, sink_en, ch_en}, 4'h0);
        over_v = 1'b0; cyc(4); on_chk(2'h3, 1'b0, 4'h7);
        host.wr(8'h02, 8'h07); cyc(3); off_chk(1'b1);
        // detectors ignored while dark, corner then random patterns
        host.wr(8'h00, 8'h00);
        opn = 2'h3;
        sht = 2'h3;
        cyc(5);
        host.rd(8'h00, d); chk(d, 8'h00);
        for (int i = 0; i < 3; i++) begin
            opn = 2'($urandom);
            sht = 2'($urandom);
            cyc(3);
            host.rd(8'h00, d); chk(d, 8'h00);
        end
        opn = 2'h0;
        sht = 2'h0;
        // strobe ignored while the clock enable is low
        @(negedge core_clk);
        ce = 1'b0;
        host.wr(8'h02, 8'h10);
        ce = 1'b1;
        cyc(3); off_chk(1'b1);
        conclude();
    end
endmodule
